/* File: hbsc_serial_ctrl.v */
// serial control and status port of the six half-bridge driver
//
// Contract
// - select falling edge starts a new frame
// - shifted control word applied only on select rising edge
// - input bit sampled on each falling serial clock edge
// - serial output driven from select fall, released while select high
// - serial output changes on select fall or rising clock edge, stable otherwise
// - status word shifted out lsb first, pre-warning first
// - control bit 0 clears latched supply, short and overtemp flags
// - bits 1..12 switch low1, high1 ... high6; high means on
// - bit 13 low enables open-load checking
// - bit 14 picks 12 ms or 1.5 ms short delay
// - bit 15 low puts device in standby
// - serial port keeps working during software standby
// - enable pin low puts device in standby
// - fault flag pulled low on overtemp or overcurrent
// - status: prewarn, switch states, short, enable, supply fail
// - overtemp shutdown returns all sixteen status bits high
// - reset control word has bits 15..13 high, rest low
// - outputs off unless both enables high, serial stays active
`include "hbsc_defines.vh"
module hbsc_serial_ctrl (
	input wire ref_clk,
	input wire rst_b,
	input wire clkEn,
	input wire selectN,
	input wire serialClk,
	input wire serial_in,
	input wire enablePin,
	output reg serialOut,
	output reg serialOutEn,
	output wire faultN_o,
	output wire faultN_oe,
	input wire tempPrewarn,
	input wire overTemp,
	input wire overCurrent,
	input wire supplyUnder,
	input wire [11:0] openLoad,
	output reg [11:0] switchOn,
	output reg open_load_check_n,
	output reg short_delay_select,
	output reg soft_enable,
	output reg [`HBSC_TMR_W-1:0] shortDelayCycles,
	output reg active
);
	// products are 32-bit integers, cut to the timer width on purpose
	localparam integer LONG_INT = `HBSC_SCT_LONG_US * `HBSC_CLK_MHZ;
	localparam integer SHORT_INT = `HBSC_SCT_SHORT_US * `HBSC_CLK_MHZ;
	localparam [`HBSC_TMR_W-1:0] LONG_CYC = LONG_INT[`HBSC_TMR_W-1:0];
	localparam [`HBSC_TMR_W-1:0] SHORT_CYC = SHORT_INT[`HBSC_TMR_W-1:0];

	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	reg rstS1_q;
	reg rstN_q;
	// async assert, release through two flops
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstS1_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rstS1_q <= 1'b1;
			rstN_q <= rstS1_q;
		end
	end
	wire selS;
	wire sckS;
	wire dinS;
	wire enS;
	wire otS;
	wire ocS;
	wire uvS;
	wire twS;
	wire [11:0] olS;
	wire selActS;
	// select enters inverted so the flop reset value means idle: no false edge after reset
	hbsc_sync uSel (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(~selectN),
		.syncOut(selActS));
	assign selS = ~selActS;
	hbsc_sync uSck (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(serialClk), .syncOut(sckS));
	hbsc_sync uDin (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(serial_in), .syncOut(dinS));
	hbsc_sync uEn (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(enablePin), .syncOut(enS));
	hbsc_sync uOt (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(overTemp), .syncOut(otS));
	hbsc_sync uOc (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(overCurrent), .syncOut(ocS));
	hbsc_sync uUv (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(supplyUnder), .syncOut(uvS));
	hbsc_sync uTw (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(tempPrewarn), .syncOut(twS));
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : gOl
			hbsc_sync uOl (.clk(ref_clk), .rstN(rstN_q), .ce(clkEn), .pinIn(openLoad[gi]),
				.syncOut(olS[gi]));
		end
	endgenerate

	// ----------------------------------------
	// edge detection on synchronised pins
	// ----------------------------------------
	reg selD_q;
	reg sckD_q;
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			selD_q <= 1'b1;
			sckD_q <= 1'b0;
		end else if (clkEn) begin
			selD_q <= selS;
			sckD_q <= sckS;
		end
	end
	wire selFall = selD_q & ~selS;
	wire selRise = ~selD_q & selS;
	wire inFrame = ~selS;
	wire sckFall = inFrame & sckD_q & ~sckS;
	wire sckRise = inFrame & ~sckD_q & sckS;

	// ----------------------------------------
	// latched status flags
	// ----------------------------------------
	reg supplyFail_q;
	reg shortDet_q;
	reg otShut_q;
	reg [`HBSC_W-1:0] ctrl_q;
	reg [`HBSC_W-1:0] rxShift_q;
	wire clrReq = selRise & rxShift_q[`HBSC_BIT_CLR];
	reg [`HBSC_TMR_W-1:0] ocTmr_q;
	wire ocTrip = ocS & (ocTmr_q >= shortDelayCycles);
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			supplyFail_q <= 1'b0;
			shortDet_q <= 1'b0;
			otShut_q <= 1'b0;
		end else if (clkEn) begin
			supplyFail_q <= uvS | (supplyFail_q & ~clrReq);
			shortDet_q <= ocTrip | (shortDet_q & ~clrReq);
			otShut_q <= otS | (otShut_q & ~clrReq);
		end
	end
	// overcurrent must persist for the chosen delay before shutdown
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			ocTmr_q <= {`HBSC_TMR_W{1'b0}};
		end else if (clkEn) begin
			if (!ocS) begin
				ocTmr_q <= {`HBSC_TMR_W{1'b0}};
			end else if (!ocTrip) begin
				ocTmr_q <= ocTmr_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// status word assembly
	// ----------------------------------------
	reg [`HBSC_W-1:0] statusWord;
	always @* begin
		statusWord = {`HBSC_W{1'b0}};
		statusWord[`HBSC_ST_TP] = twS;
		statusWord[`HBSC_SW_HI:`HBSC_SW_LO] = switchOn | (olS & {12{~open_load_check_n}});
		statusWord[`HBSC_ST_SCD] = shortDet_q;
		statusWord[`HBSC_ST_EN] = active;
		statusWord[`HBSC_ST_PSF] = supplyFail_q;
		if (otShut_q) begin
			statusWord = `HBSC_ALL_ONES;
		end
	end

	// ----------------------------------------
	// frame shifting
	// ----------------------------------------
	reg [`HBSC_W-1:0] txShift_q;
	// sample on falling edge, keep last sixteen bits
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			rxShift_q <= {`HBSC_W{1'b0}};
		end else if (clkEn) begin
			if (sckFall) begin
				rxShift_q <= {dinS, rxShift_q[`HBSC_W-1:1]};
			end
		end
	end
	// capture status, lsb first, received bits follow
	// received bits queue behind the status, so they leave sixteen clocks later
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			txShift_q <= {`HBSC_W{1'b0}};
		end else if (clkEn) begin
			if (selFall) begin
				txShift_q <= statusWord;
			end else if (sckFall) begin
				txShift_q <= {dinS, txShift_q[`HBSC_W-1:1]};
			end
		end
	end
	// serial output register and enable
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
		end else if (clkEn) begin
			// drive from select fall, release on high
			serialOutEn <= inFrame;
			if (selFall) begin
				serialOut <= statusWord[0];
			end else if (sckRise) begin
				serialOut <= txShift_q[1];
			end
		end
	end

	// ----------------------------------------
	// control word and derived outputs
	// ----------------------------------------
	// apply on select rise, even in standby
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			ctrl_q <= `HBSC_CTRL_RST;
		end else if (clkEn) begin
			if (selRise) begin
				ctrl_q <= rxShift_q;
			end
		end
	end
	// registered outputs decoded from control word
	always @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			switchOn <= 12'h000;
			open_load_check_n <= 1'b1;
			short_delay_select <= 1'b1;
			soft_enable <= 1'b1;
			shortDelayCycles <= LONG_CYC;
			active <= 1'b0;
		end else if (clkEn) begin
			active <= ctrl_q[`HBSC_BIT_SE] & enS;
			// switch bits, shut off on fault
			switchOn <= (ctrl_q[`HBSC_SW_HI:`HBSC_SW_LO] &
				{12{ctrl_q[`HBSC_BIT_SE] & enS & ~shortDet_q & ~otShut_q}});
			open_load_check_n <= ctrl_q[`HBSC_BIT_OLD];
			short_delay_select <= ctrl_q[`HBSC_BIT_SCT];
			shortDelayCycles <= ctrl_q[`HBSC_BIT_SCT] ? LONG_CYC : SHORT_CYC;
			soft_enable <= ctrl_q[`HBSC_BIT_SE];
		end
	end

	// ----------------------------------------
	// open-drain fault flag
	// ----------------------------------------
	// pull low on fault
	assign faultN_o = 1'b0;
	assign faultN_oe = otS | ocS | otShut_q | shortDet_q;
endmodule // hbsc_serial_ctrl

/* File: hbsc_defines.vh */
// constants for the half-bridge serial control block
`ifndef HBSC_DEFINES_VH
`define HBSC_DEFINES_VH
`define HBSC_W 16
`define HBSC_CNT_W 5
`define HBSC_BIT_CLR 0
`define HBSC_SW_LO 1
`define HBSC_SW_HI 12
`define HBSC_BIT_OLD 13
`define HBSC_BIT_SCT 14
`define HBSC_BIT_SE 15
`define HBSC_ST_TP 0
`define HBSC_ST_SCD 13
`define HBSC_ST_EN 14
`define HBSC_ST_PSF 15
`define HBSC_CTRL_RST 16'hE000
`define HBSC_ALL_ONES 16'hFFFF
`define HBSC_CLK_MHZ 100
`define HBSC_SCT_LONG_US 12000
`define HBSC_SCT_SHORT_US 1500
`define HBSC_TMR_W 21
`endif

/* File: hbsc_sync.v */
// two-flop synchroniser for one pin
module hbsc_sync (
	input wire clk,
	input wire rstN,
	input wire ce,
	input wire pinIn,
	output reg syncOut
);
	reg meta;
	// first flop read only by second
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta <= 1'b0;
			syncOut <= 1'b0;
		end else if (ce) begin
			meta <= pinIn;
			syncOut <= meta;
		end
	end
endmodule // hbsc_sync

/* File: hbsc_monitor.sv */
// assertion checker for the serial control port
module hbsc_monitor (
	input wire ref_clk,
	input wire rst_b,
	input wire selectN,
	input wire serialClk,
	input wire enablePin,
	input wire overTemp,
	input wire serialOut,
	input wire serialOutEn,
	input wire faultN_oe,
	input wire [11:0] switchOn,
	input wire open_load_check_n,
	input wire short_delay_select,
	input wire soft_enable,
	input wire [20:0] shortDelayCycles,
	input wire active
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// sync delay of the pins sets the repeat counts
	sequence sQuiet; (!serialClk && serialOutEn)[*6]; endsequence
	sequence sIdle; selectN[*6]; endsequence
	sequence sFrame; (!selectN)[*8]; endsequence
	sel_on_a: assert property ($fell(selectN) |-> ##[2:5] serialOutEn)
		else $error("serial out not enabled");
	tri_state_a: assert property (sIdle |-> !serialOutEn)
		else $error("serial out driven while idle");
	out_hold_a: assert property (sQuiet |-> $stable(serialOut))
		else $error("serial out moved without clock rise");
	fault_flag_a: assert property (overTemp[*4] |-> faultN_oe)
		else $error("fault flag not pulled");
	pin_standby_a: assert property ((!enablePin)[*6] |-> !active)
		else $error("active with enable pin low");
	soft_standby_a: assert property ((!soft_enable)[*2] |-> !active)
		else $error("active with soft enable low");
	switch_off_a: assert property ((!active)[*3] |-> switchOn == 12'h000)
		else $error("switch on in standby");
	delay_pick_a: assert property ($stable(short_delay_select) |->
		shortDelayCycles == (short_delay_select ? 21'd1200000 : 21'd150000))
		else $error("short delay count wrong");
	frame_hold_a: assert property (sFrame |-> $stable(soft_enable)
		&& $stable(open_load_check_n) && $stable(short_delay_select))
		else $error("control changed inside frame");
endmodule // hbsc_monitor
bind hbsc_serial_ctrl hbsc_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b),
	.selectN(selectN), .serialClk(serialClk), .enablePin(enablePin), .overTemp(overTemp),
	.serialOut(serialOut), .serialOutEn(serialOutEn), .faultN_oe(faultN_oe),
	.switchOn(switchOn), .open_load_check_n(open_load_check_n), .active(active),
	.short_delay_select(short_delay_select), .soft_enable(soft_enable),
	.shortDelayCycles(shortDelayCycles));

/* File: hbsc_host_model.sv */
// host serial master model, 160 ns clock only inside frames
module hbsc_host_model (
	output logic selectN,
	output logic serialClk,
	output logic serial_in,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle: deselected, clock parked low
	initial begin
		selectN = 1'b1;
		serialClk = 1'b0;
		serial_in = 1'b0;
	end
	// one frame of n bits; reply bit read just before each rise
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
		r = '0;
		selectN = 1'b0;
		#200;
		for (int i = 0; i < n; i++) begin
			r[i] = serialOutEn ? serialOut : 1'bx;
			serial_in = w[i];
			serialClk = 1'b1;
			#80 serialClk = 1'b0;
			#80;
		end
		selectN = 1'b1;
		serial_in = ~serial_in; // stale data must not look valid
		#200;
	endtask
endmodule // hbsc_host_model

/* File: testbench.sv */
// self-checking bench for the half-bridge serial control port
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst_b = 1'b0, enablePin = 1'b1, overCurrent = 1'b0;
	logic tempPrewarn = 1'b0, overTemp = 1'b0, supplyUnder = 1'b0;
	logic [11:0] openLoad = 12'h000;
	logic selectN, serialClk, serial_in, serialOut, serialOutEn, faultN_oe, active;
	logic open_load_check_n, short_delay_select, soft_enable;
	logic [11:0] switchOn;
	logic [20:0] shortDelayCycles;
	logic [31:0] r;
	logic [15:0] w, prev;
	int mismatches = 0, n_checks = 0;
	// control word beside the switch drive it gives
	logic [27:0] rows [5] = '{{16'h8002, 12'h001}, {16'hC004, 12'h002},
		{16'hBFFE, 12'hFFF}, {16'h1FFE, 12'h000}, {16'hD554, 12'hAAA}};
	always #5 ref_clk = ~ref_clk;
	hbsc_host_model u_host (.selectN(selectN), .serialClk(serialClk), .serial_in(serial_in),
		.serialOut(serialOut), .serialOutEn(serialOutEn));
	hbsc_serial_ctrl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(1'b1),
		.selectN(selectN), .serialClk(serialClk), .serial_in(serial_in),
		.enablePin(enablePin), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.faultN_o(), .faultN_oe(faultN_oe), .tempPrewarn(tempPrewarn), .overTemp(overTemp),
		.overCurrent(overCurrent), .supplyUnder(supplyUnder), .openLoad(openLoad),
		.switchOn(switchOn), .open_load_check_n(open_load_check_n),
		.short_delay_select(short_delay_select), .soft_enable(soft_enable),
		.shortDelayCycles(shortDelayCycles), .active(active));
	// status expected at frame start, no faults and no open loads
	function automatic logic [31:0] st(input logic [15:0] c);
		return {17'h0, c[15], 1'b0, c[15] ? c[12:1] : 12'h000, 1'b0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d n_checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------
	// main sequence, all changes 1 ns after a clock rise
	// ------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (10) @(posedge ref_clk);
		#1 chk({soft_enable, short_delay_select, open_load_check_n, switchOn}, 32'h7000, "reset");
		prev = 16'hE000;
		foreach (rows[i]) begin
			w = rows[i][27:12];
			u_host.xfer({16'h0, w}, 16, r);
			chk(r, st(prev), "status word");
			chk(switchOn, rows[i][11:0], "switches");
			chk({soft_enable, short_delay_select, open_load_check_n}, w[15:13], "modes");
			chk(shortDelayCycles, w[14] ? 1200000 : 150000, "short delay");
			prev = w;
		end
		supplyUnder = 1'b1;
		tempPrewarn = 1'b1;
		#100 supplyUnder = 1'b0;
		u_host.xfer(32'h8000, 16, r);
		chk(r, st(prev) | 32'h8001, "supply and prewarn");
		tempPrewarn = 1'b0;
		overTemp = 1'b1;
		#100 chk(faultN_oe, 1, "fault flag");
		u_host.xfer(32'h8000, 16, r);
		chk(r, 32'hFFFF, "overtemp status");
		overTemp = 1'b0;
		#100 u_host.xfer(32'h8001, 16, r);
		u_host.xfer(32'h8000, 16, r);
		chk(r, 32'h4000, "cleared status");
		u_host.xfer({8'h0, 16'h8006, 8'h5A}, 24, r);
		chk(r, {8'h0, 8'h5A, 16'h4000}, "pass through");
		chk(switchOn, 12'h003, "last sixteen");
		// open-load check is on (bit 13 low), last switch reports open
		openLoad = 12'h800;
		#100 u_host.xfer(32'h8006, 16, r);
		chk(r, st(16'h8006) | 32'h1000, "open load status");
		openLoad = 12'h000;
		enablePin = 1'b0;
		#100 chk({active, switchOn}, 0, "pin standby");
		// mid-run reset brings back the power-on control word
		enablePin = 1'b1;
		rst_b = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (10) @(posedge ref_clk);
		#1 chk({active, soft_enable, short_delay_select, open_load_check_n, switchOn}, 16'hF000, "mid reset");
		final_report();
	end
	// watchdog well beyond the eleven frames above
	initial begin
		#300000;
		mismatches++;
		final_report();
	end
endmodule // testbench
